// File: subsystem_reset_boot_handoff.sv
// device reset combiner, subsystem release and control boot handoff
// assumes rst_n is power-on reset; reset pins are open-drain, shared off chip
// Notes on behaviour
// R01: power-on reset drives both reset pins low
// R02: power-on reset can never be disabled
// R03: reset clears logic, tristates all gpio
// R04: external low on pins extends reset
// R05: irq, watchdogs ORed with por drive digital pin
// R06: only master released after power-up
// R07: writing 1 releases control, analog
// R08: board ties both reset pins together
// R09: boot source chosen by master commands
// R10: ram and flash commands jump there
// R11: async serial and spi loaders
// R12: i2c and parallel gpio loaders
// R13: resident image takes over execution
// R14: later commands still served after boot
// R15: master wakes loader with irq one
// R16: undefined command words are ignored
`timescale 1ns/1ns
module subsystem_reset_boot_handoff
  import reset_boot_pkg::*;
#(
  parameter int POR_CYCLES = POR_HOLD_CYCLES
) (
  // clock and power-on reset
  input  wire logic                  clk_sys,
  input  wire logic                  rst_n,
  // reset pins, open drain
  input  wire logic                  analog_reset_pin_in,
  output logic                       analog_reset_pin_out,
  output logic                       analog_reset_pin_oe,
  input  wire logic                  digital_reset_pin_in,
  output logic                       digital_reset_pin_out,
  output logic                       digital_reset_pin_oe,
  // internal reset requests, active high
  input  wire logic                  irq_ctrl_reset_req,
  input  wire logic                  watchdog0_reset_req,
  input  wire logic                  watchdog1_reset_req,
  input  wire logic                  nmi_watchdog_reset_req,
  // subsystem reset config bits from master
  input  wire logic                  control_cpu_release_bit,
  input  wire logic                  analog_interface_release_bit,
  // interprocessor channel
  input  wire logic                  wake_interprocessor_irq,
  input  wire logic                  cmd_valid,
  input  wire logic [CMD_WIDTH-1:0]  boot_mode_command_word,
  input  wire logic                  image_ready,
  // subsystem resets and gpio
  output logic                       master_reset_n,
  output logic                       control_reset_n,
  output logic                       analog_reset_n,
  output logic                       gpio_oe_allow,
  // boot status
  output logic [2:0]                 boot_source,
  output logic                       control_booted,
  output logic                       loader_awake,
  output logic                       loader_loading,
  output logic                       housekeeping_pulse
);
  boot_link_if link ();

  // pins come from outside, two flops each
  logic [1:0] pin_s;
  reset_sync #(.W(2)) u_sync (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .d       ({analog_reset_pin_in, digital_reset_pin_in}),
    .q       (pin_s)
  );

  // R02: por counter, no disable path
  logic [15:0] por_cnt;
  logic        por_active;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      por_cnt    <= '0;
      por_active <= 1'b1;
    end else if (por_cnt < 16'(POR_CYCLES)) begin
      por_cnt    <= por_cnt + 16'h0001;
    end else begin
      por_active <= 1'b0;
    end
  end

  // R05: merged internal requests
  logic int_req;
  assign int_req = irq_ctrl_reset_req | watchdog0_reset_req
                 | watchdog1_reset_req | nmi_watchdog_reset_req;

  // R01: R05: drive pins low
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      analog_reset_pin_oe  <= 1'b1;
      digital_reset_pin_oe <= 1'b1;
    end else begin
      analog_reset_pin_oe  <= por_active;
      digital_reset_pin_oe <= por_active | int_req;
    end
  end

  // open drain only ever drives low
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      analog_reset_pin_out  <= 1'b0;
      digital_reset_pin_out <= 1'b0;
    end else begin
      analog_reset_pin_out  <= 1'b0;
      digital_reset_pin_out <= 1'b0;
    end
  end

  // R04: R08: low pin holds reset
  logic dev_reset;
  assign dev_reset = por_active | ~pin_s[0] | ~pin_s[1];
  assign link.in_reset = dev_reset;

  // R03: R06: R07: subsystem releases
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      master_reset_n  <= 1'b0;
      control_reset_n <= 1'b0;
      analog_reset_n  <= 1'b0;
      gpio_oe_allow   <= 1'b0;
    end else begin
      master_reset_n  <= ~dev_reset;
      control_reset_n <= ~dev_reset & control_cpu_release_bit;
      analog_reset_n  <= ~dev_reset & analog_interface_release_bit;
      gpio_oe_allow   <= ~dev_reset;
    end
  end

  // R09: boot selected by command words only
  logic       awake_w;
  logic       loading_w;
  logic       hk_w;
  boot_loader u_loader (
    .clk_sys      (clk_sys),
    .rst_n        (rst_n),
    .wake         (wake_interprocessor_irq & control_reset_n),
    .cmd_valid    (cmd_valid & control_reset_n),
    .cmd_word     (boot_mode_command_word),
    .image_ready  (image_ready),
    .link         (link.boot_end),
    .awake        (awake_w),
    .loading      (loading_w),
    .housekeeping (hk_w)
  );

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      boot_source        <= SRC_NONE;
      control_booted     <= 1'b0;
      loader_awake       <= 1'b0;
      loader_loading     <= 1'b0;
      housekeeping_pulse <= 1'b0;
    end else begin
      boot_source        <= link.boot_src;
      control_booted     <= link.booted;
      loader_awake       <= awake_w;
      loader_loading     <= loading_w;
      housekeeping_pulse <= hk_w;
    end
  end
endmodule

// File: reset_boot_pkg.sv
// constants for the reset combiner and control boot handoff
// assumes one 25 MHz system clock
package reset_boot_pkg;
  localparam int          CMD_WIDTH          = 32;
  localparam logic [31:0] CMD_BOOT_RAM       = 32'h0000_0001;
  localparam logic [31:0] CMD_BOOT_FLASH     = 32'h0000_0002;
  localparam logic [31:0] CMD_LOAD_ASYNC     = 32'h0000_0003;
  localparam logic [31:0] CMD_LOAD_SPI       = 32'h0000_0004;
  localparam logic [31:0] CMD_LOAD_I2C       = 32'h0000_0005;
  localparam logic [31:0] CMD_LOAD_PARALLEL  = 32'h0000_0006;
  localparam logic [2:0]  SRC_NONE           = 3'h0;
  localparam logic [2:0]  SRC_RAM            = 3'h1;
  localparam logic [2:0]  SRC_FLASH          = 3'h2;
  localparam logic [2:0]  SRC_ASYNC          = 3'h3;
  localparam logic [2:0]  SRC_SPI            = 3'h4;
  localparam logic [2:0]  SRC_I2C            = 3'h5;
  localparam logic [2:0]  SRC_PARALLEL       = 3'h6;
  localparam int          CLK_MHZ            = 25;
  localparam int          POR_HOLD_US        = 2;
  localparam int          POR_HOLD_CYCLES    = POR_HOLD_US * CLK_MHZ;
  localparam int          GPIO_WIDTH         = 8;
endpackage

// File: boot_link_if.sv
// carries reset state, boot source and booted flag between the reset and boot modules
// assumes both ends on clk_sys
`timescale 1ns/1ns
interface boot_link_if;
  logic       in_reset;
  logic [2:0] boot_src;
  logic       booted;
  modport reset_end (output in_reset, input booted, boot_src);
  modport boot_end  (input in_reset, output booted, boot_src);
endinterface

// File: boot_loader.sv
// control boot loader command interpreter
// assumes commands arrive as one-cycle strobes on clk_sys
`timescale 1ns/1ns
module boot_loader
  import reset_boot_pkg::*;
(
  input  wire logic                 clk_sys,
  input  wire logic                 rst_n,
  input  wire logic                 wake,
  input  wire logic                 cmd_valid,
  input  wire logic [CMD_WIDTH-1:0] cmd_word,
  input  wire logic                 image_ready,
  boot_link_if.boot_end             link,
  output logic                      awake,
  output logic                      loading,
  output logic                      housekeeping
);
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_WAIT = 4'b0010,
    ST_LOAD = 4'b0100,
    ST_RUN  = 4'b1000
  } ldr_state_e;
  ldr_state_e state;

  function automatic logic [2:0] decode_cmd(input logic [31:0] w);
    case (w)
      CMD_BOOT_RAM:      decode_cmd = SRC_RAM;
      CMD_BOOT_FLASH:    decode_cmd = SRC_FLASH;
      CMD_LOAD_ASYNC:    decode_cmd = SRC_ASYNC;
      CMD_LOAD_SPI:      decode_cmd = SRC_SPI;
      CMD_LOAD_I2C:      decode_cmd = SRC_I2C;
      CMD_LOAD_PARALLEL: decode_cmd = SRC_PARALLEL;
      default:           decode_cmd = SRC_NONE;
    endcase
  endfunction

  logic [2:0] src;
  assign src = decode_cmd(cmd_word);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state         <= ST_IDLE;
      link.boot_src <= SRC_NONE;
      link.booted   <= 1'b0;
      housekeeping  <= 1'b0;
    end else if (link.in_reset) begin
      state         <= ST_IDLE;
      link.boot_src <= SRC_NONE;
      link.booted   <= 1'b0;
      housekeeping  <= 1'b0;
    end else begin
      housekeeping <= 1'b0;
      case (state)
        // R15: wake on irq
        ST_IDLE: if (wake) state <= ST_WAIT;
        ST_WAIT: begin
          // R16: unknown word ignored
          if (cmd_valid && src != SRC_NONE) begin
            link.boot_src <= src;
            // R10: ram or flash jump
            if (src == SRC_RAM || src == SRC_FLASH) begin
              state       <= ST_RUN;
              link.booted <= 1'b1;
            // R11: R12: peripheral load
            end else begin
              state <= ST_LOAD;
            end
          end
        end
        // R13: hand to image
        ST_LOAD: if (image_ready) begin
          state       <= ST_RUN;
          link.booted <= 1'b1;
        end
        // R14: further commands served
        ST_RUN: housekeeping <= cmd_valid;
        default: state <= ST_IDLE;
      endcase
    end
  end

  assign awake   = (state != ST_IDLE);
  assign loading = (state == ST_LOAD);
endmodule

// File: reset_sync.sv
// two-flop synchroniser for pin levels
// assumes asynchronous inputs
`timescale 1ns/1ns
module reset_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;
  // reset reads as pin low, so reset holds until two clean high samples
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule

// File: reset_boot_assertions.sv
// port checks on the reset combiner and control boot handoff
// assumes one clk_sys domain, rst_n as power-on reset
`timescale 1ns/1ns
module reset_boot_assertions
  import reset_boot_pkg::*;
(
  input wire logic                 clk_sys, rst_n, cmd_valid, image_ready,
  input wire logic                 irq_ctrl_reset_req, watchdog0_reset_req,
  input wire logic                 watchdog1_reset_req, nmi_watchdog_reset_req,
  input wire logic                 control_cpu_release_bit, analog_interface_release_bit,
  input wire logic                 wake_interprocessor_irq, digital_reset_pin_in,
  input wire logic [CMD_WIDTH-1:0] boot_mode_command_word,
  input wire logic                 analog_reset_pin_oe, analog_reset_pin_out,
  input wire logic                 digital_reset_pin_oe, digital_reset_pin_out,
  input wire logic                 master_reset_n, control_reset_n, analog_reset_n,
  input wire logic                 gpio_oe_allow, control_booted, loader_awake,
  input wire logic                 loader_loading, housekeeping_pulse,
  input wire logic [2:0]           boot_source
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  logic bad;
  assign bad = boot_mode_command_word == 32'h0 || boot_mode_command_word > CMD_LOAD_PARALLEL;
  chk_por_pin_hold: assert property ($rose(rst_n) |-> analog_reset_pin_oe && digital_reset_pin_oe)
    else $error("reset pins let go at power-on release");
  chk_pins_open_drain: assert property (!analog_reset_pin_out && !digital_reset_pin_out)
    else $error("reset pin driven high");
  chk_pin_extends_reset: assert property (!digital_reset_pin_in |-> ##[1:4] !master_reset_n)
    else $error("low pin did not reset the device");
  chk_req_drives_pin: assert property (irq_ctrl_reset_req || watchdog0_reset_req ||
    watchdog1_reset_req || nmi_watchdog_reset_req |=> digital_reset_pin_oe)
    else $error("reset request not on pin");
  chk_gpio_tristate: assert property (!master_reset_n || analog_reset_pin_oe |-> !gpio_oe_allow)
    else $error("gpio enabled in reset");
  chk_ctrl_release: assert property (control_reset_n
    |-> $past(control_cpu_release_bit) && master_reset_n)
    else $error("control released without its bit");
  chk_ana_release: assert property (analog_reset_n
    |-> $past(analog_interface_release_bit) && master_reset_n)
    else $error("analog released without its bit");
  chk_flash_boot: assert property (cmd_valid && loader_awake && control_reset_n && !control_booted
    && boot_mode_command_word == CMD_BOOT_FLASH |-> ##2 boot_source == SRC_FLASH && control_booted)
    else $error("flash command not taken");
  chk_bad_cmd: assert property (cmd_valid && !control_booted && (bad || !loader_awake)
    |-> ##2 $stable(boot_source))
    else $error("refused command changed source");
  chk_image_runs: assert property (image_ready && loader_loading |-> ##2 control_booted)
    else $error("loaded image not started");
  chk_housekeeping: assert property (cmd_valid && control_booted && control_reset_n
    |-> ##2 housekeeping_pulse)
    else $error("command after boot not served");
  chk_wake_loader: assert property (wake_interprocessor_irq && control_reset_n |-> ##2 loader_awake)
    else $error("loader did not wake");
endmodule
bind subsystem_reset_boot_handoff reset_boot_assertions chk_u (.*);

// File: master_model.sv
// master software and board: command channel, release bits, tied reset pins
// assumes device inputs change at the falling edge of clk_sys
`timescale 1ns/1ns
module master_model
  import reset_boot_pkg::*;
(
  input  wire logic                 clk_sys,
  input  wire logic                 analog_reset_pin_oe,
  input  wire logic                 digital_reset_pin_oe,
  output logic                      pin_level,
  output logic                      wake_interprocessor_irq = 1'b0,
  output logic                      cmd_valid = 1'b0,
  output logic [CMD_WIDTH-1:0]      boot_mode_command_word = '0,
  output logic                      control_cpu_release_bit = 1'b0,
  output logic                      analog_interface_release_bit = 1'b0
);
  logic ext_pull = 1'b0;
  assign pin_level = !(analog_reset_pin_oe || digital_reset_pin_oe || ext_pull);
  task automatic wake_up();
    @(negedge clk_sys);
    wake_interprocessor_irq = 1'b1;
    @(negedge clk_sys);
    wake_interprocessor_irq = 1'b0;
    @(negedge clk_sys);
  endtask
  // one word per strobe; idle word inverted so it never lingers
  task automatic send(input logic [CMD_WIDTH-1:0] w);
    @(negedge clk_sys);
    cmd_valid = 1'b1;
    boot_mode_command_word = w;
    @(negedge clk_sys);
    cmd_valid = 1'b0;
    boot_mode_command_word = ~w;
  endtask
endmodule

// File: testbench.sv
// self-checking bench for the reset combiner and boot handoff
// assumes master_model as far side and the bound checker
`timescale 1ns/1ns
module testbench
  import reset_boot_pkg::*;
;
  logic clk_sys = 1'b0, rst_n = 1'b0, image_ready = 1'b0;
  logic irq_ctrl_reset_req = 1'b0, watchdog0_reset_req = 1'b0;
  logic watchdog1_reset_req = 1'b0, nmi_watchdog_reset_req = 1'b0;
  logic pin_level, wake_interprocessor_irq, cmd_valid, control_cpu_release_bit;
  logic analog_interface_release_bit, analog_reset_pin_out, analog_reset_pin_oe;
  logic digital_reset_pin_out, digital_reset_pin_oe, master_reset_n, control_reset_n;
  logic analog_reset_n, gpio_oe_allow, control_booted, loader_awake, loader_loading;
  logic housekeeping_pulse;
  logic [CMD_WIDTH-1:0] boot_mode_command_word;
  logic [2:0] boot_source;
  wire analog_reset_pin_in = pin_level;
  wire digital_reset_pin_in = pin_level;
  int fail_count = 0;
  int n_checks = 0;
  always #20 clk_sys = ~clk_sys;
  master_model m_u (.*);
  subsystem_reset_boot_handoff #(.POR_CYCLES(4)) dut_u (.*);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %0h want %0h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic wait_up();
    int k;
    k = 0;
    while (master_reset_n !== 1'b1 && k < 100) begin
      cyc(1);
      k++;
    end
    if (k == 100) begin
      fail_count++;
      summarize();
    end
  endtask
  task automatic rel(input logic v);
    m_u.control_cpu_release_bit = v;
    m_u.analog_interface_release_bit = v;
    cyc(2);
    chk(control_reset_n, v);
    chk(analog_reset_n, v);
  endtask
  task automatic t_por();
    cyc(8);
    chk(analog_reset_pin_oe, 1);
    chk(digital_reset_pin_oe, 1);
    chk(gpio_oe_allow, 0);
    rst_n = 1'b1;
    wait_up();
    chk(gpio_oe_allow, 1);
    chk(control_reset_n, 0);
    m_u.ext_pull = 1'b1;
    cyc(20);
    chk(master_reset_n, 0);
    m_u.ext_pull = 1'b0;
    wait_up();
    rst_n = 1'b0;
    cyc(1);
    chk(digital_reset_pin_oe, 1);
    rst_n = 1'b1;
    wait_up();
    $display("power-on and pin hold done");
  endtask
  task automatic t_req();
    for (int i = 0; i < 4; i++) begin
      rel(1'b1);
      {nmi_watchdog_reset_req, watchdog1_reset_req, watchdog0_reset_req,
        irq_ctrl_reset_req} = 4'h1 << i;
      cyc(1);
      chk(digital_reset_pin_oe, 1);
      chk(pin_level, 0);
      cyc(4);
      chk(control_reset_n, 0);
      {nmi_watchdog_reset_req, watchdog1_reset_req, watchdog0_reset_req,
        irq_ctrl_reset_req} = 4'h0;
      wait_up();
    end
    $display("reset requests done");
  endtask
  task automatic t_boot(input int i);
    rel(1'b1);
    m_u.send(i);
    cyc(2);
    chk(boot_source, SRC_NONE);
    m_u.wake_up();
    m_u.send(32'h7);
    cyc(2);
    chk(boot_source, SRC_NONE);
    m_u.send(i);
    cyc(2);
    chk(boot_source, i);
    if (i > 2) begin
      chk(loader_loading, 1);
      image_ready = 1'b1;
      cyc(3);
    end
    chk(control_booted, 1);
    m_u.send(i);
    cyc(1);
    chk(housekeeping_pulse, 1);
    image_ready = 1'b0;
    rel(1'b0);
    watchdog1_reset_req = 1'b1;
    cyc(5);
    watchdog1_reset_req = 1'b0;
    wait_up();
    $display("boot mode %0d done", i);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    t_por();
    t_req();
    for (int i = 1; i <= 6; i++) begin
      t_boot(i);
    end
    summarize();
  end
endmodule
